// ### atc_pkg.sv
package atc_pkg;
    // clock rate and timing
    localparam int ATC_CLK_MHZ = 50;
    localparam int ATC_CONV_NS = 3600;
    localparam int ATC_CONV_CYC = (ATC_CONV_NS * ATC_CLK_MHZ + 999) / 1000;
    localparam int ATC_SAMPLE_SHORT_SCLK = 12;
    localparam int ATC_SAMPLE_LONG_SCLK = 44;
    localparam int ATC_CMD_SCLK = 4;
    localparam int ATC_FRAME_BITS = 16;
    localparam int ATC_SAR_BITS = 14;
    localparam int ATC_CH_W = 3;
    localparam int ATC_NUM_CH = 8;
    localparam int ATC_SEL_W = 4;
    localparam int ATC_BBM_CYC = 2;
    // selection codes: channels 0..7, then three test voltages
    localparam logic [3:0] ATC_SEL_TEST0 = 4'hb;
    localparam logic [3:0] ATC_SEL_TEST2 = 4'hd;
    localparam logic [3:0] ATC_SEL_NONE = 4'hf;

    typedef struct packed {
        logic long_sample;
        logic pseudo_diff;
        logic ext_reference;
        logic [3:0] select;
    } atc_cfg_t;

    typedef struct packed {
        logic [7:0] chan_en;
        logic [2:0] test_en;
        logic neg_en;
        logic ref_internal;
    } atc_analog_t;

    typedef enum logic [2:0] {
        ATC_IDLE,
        ATC_SAMPLE,
        ATC_CONVERT,
        ATC_DONE
    } atc_state_t;
endpackage

// ### atc_sar.sv
`timescale 1ns/1ps
`default_nettype none
module atc_sar
    import atc_pkg::*;
#(
    parameter int BITS = ATC_SAR_BITS
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // control
    input wire logic start,
    input wire logic comp_high,
    // result
    output logic [BITS-1:0] trial,
    output logic [BITS-1:0] code,
    output logic done
);
    logic [BITS-1:0] trial_reg;
    logic [BITS-1:0] mask_reg;
    logic [BITS-1:0] code_reg;
    logic done_reg;
    logic [BITS-1:0] keep;
    // drop the trial bit when the comparator says the sample is below it
    assign keep = comp_high ? trial_reg : (trial_reg & ~mask_reg);
    always_ff @(posedge clk_sys)
    begin
        done_reg <= 1'b0;
        if (srst)
        begin
            trial_reg <= '0;
            mask_reg <= '0;
            code_reg <= '0;
        end
        else if (start)
        begin
            mask_reg <= {1'b1, {(BITS-1){1'b0}}};
            trial_reg <= {1'b1, {(BITS-1){1'b0}}};
        end
        else if (mask_reg != '0)
        begin
            mask_reg <= mask_reg >> 1;
            trial_reg <= keep | (mask_reg >> 1);
            if (mask_reg[0])
            begin
                code_reg <= keep;
                done_reg <= 1'b1;
            end
        end
    end
    assign trial = trial_reg;
    assign code = code_reg;
    assign done = done_reg;
endmodule // atc_sar
`default_nettype wire

// ### atc_trigger.sv
// Functional notes
// - chip select high: output off, frame sync and serial clock ignored
// - frame sync rising edge starts operation, or chip select fall when frame sync is high at that fall
// - frame sync rise drives interrupt high
// - first bit follows frame sync rise
// - start rise drives end-of-conversion low
// - interrupt low one conversion time after start
// - start fall returns interrupt high
// - route channel or one test voltage
// - break before make on channel switch
// - single-ended or pseudodifferential pairs
// - internal or external reference select
// - successive approximation after sampling ends
// - chip select fall samples frame sync mode
// - sixteen clocks then output goes off
`timescale 1ns/1ps
`default_nettype none
module atc_trigger
    import atc_pkg::*;
#(
    parameter int CONV_CYC = ATC_CONV_CYC
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // serial link pins
    input wire logic chip_select_n,
    input wire logic frame_sync,
    input wire logic serial_clk,
    input wire logic serial_in,
    input wire logic conversion_start_n,
    output logic serial_out,
    output logic serial_out_oe,
    output logic int_n,
    output logic eoc_n,
    // configuration
    input wire atc_pkg::atc_cfg_t cfg,
    // comparator from the charge array
    input wire logic comp_high,
    // analog controls
    output atc_pkg::atc_analog_t analog,
    output logic [ATC_SAR_BITS-1:0] dac_code,
    output logic [ATC_SAR_BITS-1:0] result,
    output logic sampling
);
    import atc_pkg::*;

    // two-flop synchronisers for all pins
    logic [4:0] meta_reg;
    logic [4:0] sync_reg;
    logic [4:0] prev_reg;
    always_ff @(posedge clk_sys)
    begin
        meta_reg <= {chip_select_n, frame_sync, serial_clk, serial_in, conversion_start_n};
        sync_reg <= meta_reg;
        prev_reg <= sync_reg;
    end
    wire cs_n_s = sync_reg[4];
    wire fs_s = sync_reg[3];
    wire sck_s = sync_reg[2];
    wire cst_s = sync_reg[0];
    wire cs_fall = prev_reg[4] & ~cs_n_s;
    wire fs_rise = ~prev_reg[3] & fs_s & ~cs_n_s;
    wire sck_rise = ~prev_reg[2] & sck_s & ~cs_n_s;
    wire sck_fall = prev_reg[2] & ~sck_s & ~cs_n_s;
    wire cst_rise = ~prev_reg[0] & cst_s;
    wire cst_fall = prev_reg[0] & ~cst_s;

    // frame framing
    logic fs_mode_reg;
    logic active_reg;
    logic [5:0] bit_cnt_reg;
    logic [15:0] shift_reg;
    logic out_reg;
    logic oe_reg;
    logic [ATC_SAR_BITS-1:0] result_reg;
    // the mode sampled at this very chip-select fall decides, not the stored one
    wire frame_start = cs_fall ? fs_s : (fs_mode_reg & fs_rise);
    wire [5:0] sample_end = cfg.long_sample ? 6'(ATC_CMD_SCLK + ATC_SAMPLE_LONG_SCLK)
                                            : 6'(ATC_CMD_SCLK + ATC_SAMPLE_SHORT_SCLK);
    wire frame_sample_done = active_reg & sck_fall & (bit_cnt_reg == sample_end - 6'h1);

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            fs_mode_reg <= 1'b0;
            active_reg <= 1'b0;
            bit_cnt_reg <= '0;
            shift_reg <= '0;
            out_reg <= 1'b0;
            oe_reg <= 1'b0;
        end
        else if (cs_n_s)
        begin
            active_reg <= 1'b0;
            oe_reg <= 1'b0;
        end
        else
        begin
            if (cs_fall)
                fs_mode_reg <= ~fs_s;
            if (frame_start)
            begin
                active_reg <= 1'b1;
                bit_cnt_reg <= '0;
                shift_reg <= {result_reg, 2'b00};
                out_reg <= result_reg[ATC_SAR_BITS-1];
                oe_reg <= 1'b1;
            end
            else if (active_reg)
            begin
                if (sck_fall)
                begin
                    bit_cnt_reg <= bit_cnt_reg + 6'h1;
                    if (bit_cnt_reg == 6'(ATC_FRAME_BITS - 1))
                        oe_reg <= 1'b0;
                    if (bit_cnt_reg == sample_end - 6'h1)
                        active_reg <= 1'b0;
                end
                if (sck_rise && bit_cnt_reg != '0)
                begin
                    shift_reg <= {shift_reg[14:0], 1'b0};
                    out_reg <= shift_reg[14];
                end
            end
        end
    end

    // sample and conversion sequencing
    atc_state_t state_reg;
    logic [15:0] conv_cnt_reg;
    logic int_reg;
    logic eoc_reg;
    logic samp_reg;
    logic sar_start_reg;
    logic [ATC_SAR_BITS-1:0] sar_code;
    logic [ATC_SAR_BITS-1:0] sar_trial;
    logic sar_done;
    wire conv_begin = frame_sample_done | cst_rise;
    always_ff @(posedge clk_sys)
    begin
        sar_start_reg <= 1'b0;
        if (srst)
        begin
            state_reg <= ATC_IDLE;
            conv_cnt_reg <= '0;
            int_reg <= 1'b1;
            eoc_reg <= 1'b1;
            samp_reg <= 1'b0;
            result_reg <= '0;
        end
        else
        begin
            if (frame_start)
                int_reg <= 1'b1;
            if (cst_fall)
            begin
                int_reg <= 1'b1;
                samp_reg <= 1'b1;
                state_reg <= ATC_SAMPLE;
            end
            else if (frame_start)
            begin
                samp_reg <= 1'b1;
                state_reg <= ATC_SAMPLE;
            end
            else if (conv_begin)
            begin
                samp_reg <= 1'b0;
                eoc_reg <= 1'b0;
                conv_cnt_reg <= 16'(CONV_CYC - 1);
                sar_start_reg <= 1'b1;
                state_reg <= ATC_CONVERT;
            end
            else
            begin
                case (state_reg)
                    ATC_CONVERT:
                    begin
                        if (sar_done)
                            result_reg <= sar_code;
                        if (conv_cnt_reg == '0)
                        begin
                            int_reg <= 1'b0;
                            eoc_reg <= 1'b1;
                            state_reg <= ATC_DONE;
                        end
                        else
                            conv_cnt_reg <= conv_cnt_reg - 16'h1;
                    end
                    ATC_IDLE, ATC_SAMPLE, ATC_DONE:
                        state_reg <= state_reg;
                    default:
                        state_reg <= ATC_IDLE;
                endcase
            end
        end
    end

    atc_sar #(
        .BITS(ATC_SAR_BITS)
    ) u_sar (
        .clk_sys(clk_sys),
        .srst(srst),
        .start(sar_start_reg),
        .comp_high(comp_high),
        .trial(sar_trial),
        .code(sar_code),
        .done(sar_done)
    );

    // input multiplexer with break-before-make
    function automatic logic [7:0] atc_chan_decode(input logic [3:0] sel, input logic pd);
        logic [7:0] v;
        v = '0;
        if (sel < 4'(ATC_NUM_CH))
        begin
            if (pd)
                v[{sel[1:0], 1'b0}] = 1'b1;
            else
                v[sel[2:0]] = 1'b1;
        end
        return v;
    endfunction

    logic [3:0] cur_sel_reg;
    logic cur_pd_reg;
    logic [1:0] bbm_cnt_reg;
    atc_analog_t analog_reg;
    wire [3:0] sel_want = cfg.select;
    // a mode change moves the switches as well, so it breaks first too
    wire sel_change = (sel_want != cur_sel_reg) || (cfg.pseudo_diff != cur_pd_reg);
    wire [7:0] chan_want = atc_chan_decode(cur_sel_reg, cur_pd_reg);
    wire is_test = cur_sel_reg >= ATC_SEL_TEST0 && cur_sel_reg <= ATC_SEL_TEST2;
    wire [1:0] test_idx = 2'(cur_sel_reg - ATC_SEL_TEST0);
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            cur_sel_reg <= ATC_SEL_NONE;
            cur_pd_reg <= 1'b0;
            bbm_cnt_reg <= '0;
            analog_reg <= '0;
        end
        else
        begin
            analog_reg.ref_internal <= ~cfg.ext_reference;
            analog_reg.neg_en <= cfg.pseudo_diff;
            if (sel_change)
            begin
                analog_reg.chan_en <= '0;
                analog_reg.test_en <= '0;
                cur_sel_reg <= sel_want;
                cur_pd_reg <= cfg.pseudo_diff;
                bbm_cnt_reg <= 2'(ATC_BBM_CYC);
            end
            else if (bbm_cnt_reg != '0)
                bbm_cnt_reg <= bbm_cnt_reg - 2'h1;
            else
            begin
                analog_reg.chan_en <= chan_want;
                analog_reg.test_en <= is_test ? 3'(3'h1 << test_idx) : 3'h0;
            end
        end
    end

    assign serial_out = out_reg;
    assign serial_out_oe = oe_reg;
    assign int_n = int_reg;
    assign eoc_n = eoc_reg;
    assign analog = analog_reg;
    // the comparator must judge the trial that the sequencer holds now
    assign dac_code = sar_trial;
    assign result = result_reg;
    assign sampling = samp_reg;
endmodule // atc_trigger
`default_nettype wire

// ### atc_trigger_props.sv
`timescale 1ns/1ps
`default_nettype none
module atc_trigger_props
    import atc_pkg::*;
#(
    parameter int CONV_CYC = ATC_CONV_CYC
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // pins
    input wire logic chip_select_n,
    input wire logic frame_sync,
    input wire logic conversion_start_n,
    input wire logic serial_out_oe,
    input wire logic int_n,
    input wire logic eoc_n,
    // switches
    input wire atc_pkg::atc_analog_t analog
);
    localparam int CLO = CONV_CYC - 1;
    localparam int CHI = CONV_CYC + 1;
    wire logic [10:0] sw = {analog.chan_en, analog.test_en};
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    AST_CS_OFF: assert property (chip_select_n [*5] |-> !serial_out_oe)
        else $error("oe while deselected");
    AST_FS_INT: assert property (!chip_select_n && $rose(frame_sync) |-> ##[1:5] int_n)
        else $error("int kept low");
    AST_FS_OE: assert property (
        !chip_select_n && $rose(frame_sync) |-> ##[1:5] serial_out_oe)
        else $error("no output on frame");
    AST_CST_EOC: assert property ($rose(conversion_start_n) |-> ##[1:5] !eoc_n)
        else $error("eoc not low");
    AST_CST_INT: assert property ($fell(conversion_start_n) |-> ##[1:5] int_n)
        else $error("int not released");
    AST_INT_TIME: assert property ($fell(eoc_n) |-> ##[CLO:CHI] (!int_n && eoc_n))
        else $error("int timing");
    AST_NO_INT_CONV: assert property (!eoc_n |-> int_n)
        else $error("int during conversion");
    AST_ONE_SEL: assert property ($onehot0(sw))
        else $error("two inputs joined");
    AST_BBM: assert property (sw != $past(sw) |-> $past(sw) == 11'h000 || sw == 11'h000)
        else $error("make before break");
    AST_NEG: assert property (analog.neg_en |-> (analog.chan_en & 8'haa) == 8'h00)
        else $error("odd input as positive");
endmodule // atc_trigger_props

bind atc_trigger atc_trigger_props #(.CONV_CYC(CONV_CYC)) u_props (.clk_sys, .srst,
    .chip_select_n, .frame_sync, .conversion_start_n, .serial_out_oe, .int_n, .eoc_n, .analog);
`default_nettype wire

// ### atc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module atc_host_model
(
    // host outputs
    output var logic chip_select_n,
    output var logic frame_sync,
    output var logic serial_clk,
    output var logic serial_in,
    output var logic conversion_start_n,
    // device outputs
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    initial
    begin
        chip_select_n = 1'b1;
        frame_sync = 1'b1;
        serial_clk = 1'b0;
        serial_in = 1'b0;
        conversion_start_n = 1'b1;
    end
    // serial clock at 160 ns runs inside the frame; noise() also runs it while deselected
    task automatic frame(input logic fs_mode, input int n,
        output logic [15:0] word, output logic [16:0] oe);
        frame_sync = !fs_mode;
        #100 chip_select_n = 1'b0;
        #100 frame_sync = 1'b1;
        #100;
        for (int i = 0; i < n; i++)
        begin
            serial_clk = 1'b1;
            serial_in = ~serial_in;
            #80;
            // data stands before the falling edge
            if (i < 16)
            begin
                word = {word[14:0], serial_out};
                oe = {oe[15:0], serial_out_oe};
            end
            serial_clk = 1'b0;
            frame_sync = !fs_mode;
            #80;
        end
        #20 oe = {oe[15:0], serial_out_oe};
        chip_select_n = 1'b1;
    endtask
    // frame sync and clocks while deselected
    task automatic noise();
        frame_sync = 1'b0;
        #100 frame_sync = 1'b1;
        repeat (20)
        begin
            #80 serial_clk = 1'b1;
            #80 serial_clk = 1'b0;
        end
    endtask
    task automatic ext(input int low_ns);
        conversion_start_n = 1'b0;
        #(low_ns) conversion_start_n = 1'b1;
    endtask
endmodule // atc_host_model
`default_nettype wire

// ### tb_atc_trigger.sv
`timescale 1ns/1ps
`default_nettype none
module tb_atc_trigger;
    import atc_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic chip_select_n, frame_sync, serial_clk, serial_in, conversion_start_n;
    logic serial_out, serial_out_oe, int_n, eoc_n, sampling, comp_high;
    logic [13:0] dac_code, result;
    logic [13:0] vin = 14'h0000;
    logic [13:0] last = 14'h0000;
    logic [15:0] word;
    logic [16:0] oe;
    atc_cfg_t cfg = '0;
    atc_analog_t analog;
    int err_total = 0;
    int cmp_count = 0;
    always #10 clk_sys = ~clk_sys;
    // ideal comparator against a held input level
    assign comp_high = (vin >= dac_code);
    atc_host_model host (.chip_select_n, .frame_sync, .serial_clk, .serial_in,
        .conversion_start_n, .serial_out, .serial_out_oe);
    atc_trigger #(.CONV_CYC(20)) DUT (.clk_sys, .srst, .chip_select_n, .frame_sync,
        .serial_clk, .serial_in, .conversion_start_n, .serial_out, .serial_out_oe, .int_n,
        .eoc_n, .cfg, .comp_high, .analog, .dac_code, .result, .sampling);
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim();
        if (err_total == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wait_int();
        int n;
        n = 0;
        while (int_n !== 1'b0 && n < 200)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 200)
        begin
            chk("int_timeout", 16'h0001, 16'h0000);
            end_sim();
        end
    endtask
    task automatic t_deselect();
        logic seen;
        seen = 1'b0;
        fork
            host.noise();
            repeat (170) @(negedge clk_sys) seen |= serial_out_oe | sampling | !eoc_n | int_n;
        join
        chk("deselected", {15'h0000, seen}, 16'h0000);
    endtask
    task automatic t_frame(input logic fs_mode, input logic lng, input logic [13:0] v);
        @(negedge clk_sys);
        cfg.long_sample = lng;
        vin = v;
        host.frame(fs_mode, lng ? 48 : 16, word, oe);
        chk("int_hi", {15'h0000, int_n}, 16'h0001);
        chk("word", word, {last, 2'b00});
        chk("oe", oe[16:1], 16'hffff);
        chk("oe_end", {15'h0000, oe[0]}, 16'h0000);
        wait_int();
        chk("result", {2'b00, result}, {2'b00, v});
        last = v;
    endtask
    task automatic t_ext(input logic pd, input logic [3:0] sel, input logic [13:0] v);
        atc_analog_t exp;
        exp = '0;
        exp.ref_internal = !sel[0];
        if (sel >= 4'hb)
            exp.test_en = 3'b001 << (sel - 4'hb);
        else if (pd)
            exp.chan_en = 8'h01 << {sel[1:0], 1'b0};
        else
            exp.chan_en = 8'h01 << sel;
        exp.neg_en = pd;
        @(negedge clk_sys);
        cfg = '{1'b0, pd, sel[0], sel};
        vin = v;
        fork
            host.ext(600);
            begin
                #300;
                chk("busy", {14'h0000, sampling, int_n}, 16'h0003);
                chk("analog", {3'h0, analog}, {3'h0, exp});
                #400;
                chk("eoc_low", {15'h0000, eoc_n}, 16'h0000);
            end
        join
        wait_int();
        chk("eoc_n", {15'h0000, eoc_n}, 16'h0001);
        chk("result", {2'b00, result}, {2'b00, v});
        last = v;
    endtask
    initial
    begin
        repeat (10) @(negedge clk_sys);
        srst = 1'b0;
        t_frame(1'b1, 1'b0, 14'h3fff);
        t_deselect();
        t_frame(1'b0, 1'b0, 14'h0000);
        t_frame(1'b1, 1'b1, 14'h2a5c);
        for (int s = 0; s < 8; s++)
            t_ext(1'b0, 4'(s), {4'(s), 10'h0a5});
        for (int s = 11; s < 14; s++)
            t_ext(1'b0, 4'(s), {4'(s), 10'h35a});
        for (int s = 0; s < 4; s++)
            t_ext(1'b1, 4'(s), {4'(s), 10'h1c3});
        t_frame(1'b1, 1'b0, 14'h1234);
        end_sim();
    end
endmodule // tb_atc_trigger
`default_nettype wire
